/* design/taicr_conv_seq.v */
`timescale 1ns/1ps
`include "taicr_defs.vh"

module taicr_conv_seq #(
   parameter integer W = 12
) (
   // Clock and reset
   input  wire         clk_i,
   input  wire         rst_i,
   // Control
   input  wire         start_i,
   input  wire         mode8_i,
   input  wire         bypass_i,
   input  wire         tick_i,
   // Converter sample
   input  wire [W-1:0] adc_data_i,
   // Status and result
   output reg          busy_o,
   output reg          done_o,
   output reg  [W-1:0] result_o
);

   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_CONV = 2'h1;
   localparam [1:0] S_FILT = 2'h2;

   reg [1:0]   st_ff;
   reg [4:0]   cnt_ff;
   reg [2:0]   nsmp_ff;
   reg [W+2:0] sum_ff;
   reg [W-1:0] min_ff;
   reg [W-1:0] max_ff;

   wire [4:0]   op_len_w = mode8_i ? `TAICR_OPS_8B : `TAICR_OPS_12B;
   wire [W-1:0] mask_w   = mode8_i ? {{8{1'b1}}, {(W-8){1'b0}}} : {W{1'b1}};
   wire [W-1:0] smp_w    = adc_data_i & mask_w;
   wire [W+2:0] trim_w   = sum_ff - {3'h0, min_ff} - {3'h0, max_ff};

   // ==========================================================
   // Divide by five, exact for sums below 16384 only, not over the whole range of five samples
   function [W-1:0] div5;
      input [W+2:0] x;
      reg   [W+18:0] p;
      begin
         p    = x * 16'h3334;
         div5 = p[W+15:16];
      end
   endfunction

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_ff    <= S_IDLE;
         cnt_ff   <= 5'h00;
         nsmp_ff  <= 3'h0;
         sum_ff   <= {(W+3){1'b0}};
         min_ff   <= {W{1'b1}};
         max_ff   <= {W{1'b0}};
         busy_o   <= 1'b0;
         done_o   <= 1'b0;
         result_o <= {W{1'b0}};
      end else begin
         done_o <= 1'b0;
         case (st_ff)
            S_IDLE: begin
               if (start_i) begin
                  st_ff   <= S_CONV;
                  busy_o  <= 1'b1;
                  // First acquisition already ran during the bus transfer
                  cnt_ff  <= op_len_w - `TAICR_OVERLAP_CCLKS;
                  nsmp_ff <= 3'h0;
                  sum_ff  <= {(W+3){1'b0}};
                  min_ff  <= {W{1'b1}};
                  max_ff  <= {W{1'b0}};
               end
            end
            S_CONV: begin
               if (tick_i) begin
                  if (cnt_ff == 5'h01) begin
                     sum_ff <= sum_ff + {3'h0, smp_w};
                     if (smp_w < min_ff) begin
                        min_ff <= smp_w;
                     end
                     if (smp_w > max_ff) begin
                        max_ff <= smp_w;
                     end
                     if (bypass_i) begin
                        result_o <= smp_w;
                        done_o   <= 1'b1;
                        busy_o   <= 1'b0;
                        st_ff    <= S_IDLE;
                     end else if (nsmp_ff == `TAICR_SAMPLES - 3'h1) begin
                        st_ff  <= S_FILT;
                        cnt_ff <= `TAICR_FILT_CCLKS;
                     end else begin
                        nsmp_ff <= nsmp_ff + 3'h1;
                        cnt_ff  <= op_len_w;
                     end
                  end else begin
                     cnt_ff <= cnt_ff - 5'h01;
                  end
               end
            end
            S_FILT: begin
               if (tick_i) begin
                  if (cnt_ff == 5'h01) begin
                     // Median drops the extremes, average of the middle five
                     result_o <= div5(trim_w) & mask_w;
                     done_o   <= 1'b1;
                     busy_o   <= 1'b0;
                     st_ff    <= S_IDLE;
                  end else begin
                     cnt_ff <= cnt_ff - 5'h01;
                  end
               end
            end
            default: begin
               st_ff  <= S_IDLE;
               busy_o <= 1'b0;
            end
         endcase
      end
   end

endmodule

/* design/taicr_conversion_clock_div.v */
`timescale 1ns/1ps
`include "taicr_defs.vh"

module taicr_conversion_clock_div #(
   parameter integer CLK_HZ = `TAICR_CLK_HZ
) (
   // Clock and reset
   input  wire       clk_i,
   input  wire       rst_i,
   // Control
   input  wire       run_i,
   input  wire       mode8_i,
   // Conversion clock enable
   output reg        tick_o
);

   // ==========================================================
   // Divide ratios
   localparam integer DIV12 = CLK_HZ / `TAICR_CONVERSION_CLOCK_12B_HZ;
   localparam integer DIV8  = CLK_HZ / `TAICR_CONVERSION_CLOCK_8B_HZ;

   reg  [7:0] cnt_ff;
   wire [7:0] last_w = mode8_i ? DIV8[7:0] - 8'h01 : DIV12[7:0] - 8'h01;

   // Idle divider restarts so the first tick is a full period
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_ff <= 8'h00;
         tick_o <= 1'b0;
      end else if (!run_i) begin
         cnt_ff <= 8'h00;
         tick_o <= 1'b0;
      end else if (cnt_ff >= last_w) begin
         cnt_ff <= 8'h00;
         tick_o <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
         tick_o <= 1'b0;
      end
   end

endmodule

/* design/taicr_defs.vh */
`ifndef TAICR_DEFS_VH
`define TAICR_DEFS_VH

// ==========================================================
// Function select codes
`define TAICR_FS_TEMP0      4'h0
`define TAICR_FS_AUX        4'h2
`define TAICR_FS_TEMP1      4'h4
`define TAICR_FS_DRV_X      4'h8
`define TAICR_FS_DRV_Y      4'h9
`define TAICR_FS_DRV_YX     4'hA
`define TAICR_FS_SETUP      4'hB
`define TAICR_FS_X          4'hC
`define TAICR_FS_Y          4'hD
`define TAICR_FS_Z1         4'hE
`define TAICR_FS_Z2         4'hF

// ==========================================================
// Command byte fields
`define TAICR_CMD_FS_MSB    7
`define TAICR_CMD_FS_LSB    4
`define TAICR_CMD_PD_MSB    3
`define TAICR_CMD_PD_LSB    2
`define TAICR_CMD_MODE_BIT  1
`define TAICR_SET_BYP_BIT   1
`define TAICR_SET_PULL_BIT  0
`define TAICR_PD_DOWN       2'h0

// ==========================================================
// Driver enables {x_plus, x_minus, y_plus, y_minus}
`define TAICR_DRV_NONE      4'h0
`define TAICR_DRV_X         4'hC
`define TAICR_DRV_Y         4'h3
`define TAICR_DRV_XM_YP     4'h6

// ==========================================================
// Reset values
`define TAICR_RST_PD        2'h0
`define TAICR_RST_BYPASS    1'h0
`define TAICR_RST_PULLUP    1'h0
`define TAICR_RST_RESULT    12'h000

// ==========================================================
// Timing
`define TAICR_CLK_HZ        20000000
`define TAICR_CONVERSION_CLOCK_12B_HZ   2000000
`define TAICR_CONVERSION_CLOCK_8B_HZ    4000000
`define TAICR_OPS_12B       5'h13
`define TAICR_OPS_8B        5'h10
`define TAICR_FILT_CCLKS    5'h13
`define TAICR_OVERLAP_CCLKS 5'h04
`define TAICR_SAMPLES       3'h7
`define TAICR_FS_BIT_COUNT  4'h4
`define TAICR_BYTE_BITS     4'h8

`endif

/* design/taicr_i2c_touch_adc.v */
`timescale 1ns/1ps
`include "taicr_defs.vh"

module taicr_i2c_touch_adc #(
   parameter [4:0]   ADDR_BASE = 5'h0A, // Arbitrary upper address bits
   parameter integer CLK_HZ    = `TAICR_CLK_HZ
) (
   // Clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // Serial bus
   input  wire        scl_i,
   input  wire        sda_i,
   output reg         sda_o,
   output reg         sda_oe_o,
   input  wire [1:0]  addr_select_pins_i,
   // Converter
   input  wire [11:0] adc_data_i,
   output reg  [3:0]  function_select_o,
   output reg         mux_enable_o,
   output reg         ref_single_ended_o,
   output reg  [3:0]  panel_drivers_o,
   output wire        conv_busy_o,
   // Status and setup
   output reg         data_ready_o,
   output reg         adc_powered_o,
   output reg         pen_interrupt_en_o,
   output reg         median_average_filter_bypass_o,
   output reg         pen_pullup_sel_o,
   output reg         resolution_8bit_o
);

   localparam [2:0] ST_IDLE    = 3'h0;
   localparam [2:0] ST_ADDR    = 3'h1;
   localparam [2:0] ST_ADDR_ACK = 3'h2;
   localparam [2:0] ST_CMD     = 3'h3;
   localparam [2:0] ST_CMD_ACK = 3'h4;
   localparam [2:0] ST_IGNORE  = 3'h5;
   localparam [2:0] ST_RD      = 3'h6;
   localparam [2:0] ST_RD_ACK  = 3'h7;

   // ==========================================================
   // Code decoding
   function is_meas;
      input [3:0] fs;
      begin
         is_meas = (fs == `TAICR_FS_TEMP0) || (fs == `TAICR_FS_AUX) ||
                   (fs == `TAICR_FS_TEMP1) || (fs[3:2] == 2'h3);
      end
   endfunction

   function is_drv_only;
      input [3:0] fs;
      begin
         is_drv_only = (fs == `TAICR_FS_DRV_X) || (fs == `TAICR_FS_DRV_Y) ||
                       (fs == `TAICR_FS_DRV_YX);
      end
   endfunction

   function [3:0] drv_of;
      input [3:0] fs;
      begin
         case (fs)
            `TAICR_FS_DRV_X, `TAICR_FS_X:   drv_of = `TAICR_DRV_X;
            `TAICR_FS_DRV_Y, `TAICR_FS_Y:   drv_of = `TAICR_DRV_Y;
            `TAICR_FS_DRV_YX, `TAICR_FS_Z1,
            `TAICR_FS_Z2:                   drv_of = `TAICR_DRV_XM_YP;
            default:                        drv_of = `TAICR_DRV_NONE;
         endcase
      end
   endfunction

   // ==========================================================
   // Pin synchronisers
   reg        scl_m_ff;
   reg        scl_s_ff;
   reg        scl_d_ff;
   reg        sda_m_ff;
   reg        sda_s_ff;
   reg        sda_d_ff;
   reg  [1:0] pins_m_ff;
   reg  [1:0] pins_s_ff;

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         scl_m_ff  <= 1'b1;
         scl_s_ff  <= 1'b1;
         scl_d_ff  <= 1'b1;
         sda_m_ff  <= 1'b1;
         sda_s_ff  <= 1'b1;
         sda_d_ff  <= 1'b1;
         pins_m_ff <= 2'h0;
         pins_s_ff <= 2'h0;
      end else begin
         scl_m_ff  <= scl_i;
         scl_s_ff  <= scl_m_ff;
         scl_d_ff  <= scl_s_ff;
         sda_m_ff  <= sda_i;
         sda_s_ff  <= sda_m_ff;
         sda_d_ff  <= sda_s_ff;
         pins_m_ff <= addr_select_pins_i;
         pins_s_ff <= pins_m_ff;
      end
   end

   wire scl_rise_w = scl_s_ff & ~scl_d_ff;
   wire scl_fall_w = ~scl_s_ff & scl_d_ff;
   wire start_w    = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
   wire stop_w     = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;

   // ==========================================================
   // Conversion engine
   reg         conv_go_ff;
   reg         acq_ff;
   wire        tick_w;
   wire        done_w;
   wire [11:0] seq_result_w;

   taicr_conversion_clock_div #(
      .CLK_HZ  (CLK_HZ)
   ) u_div (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .run_i   (conv_busy_o),
      .mode8_i (resolution_8bit_o),
      .tick_o  (tick_w)
   );

   taicr_conv_seq #(
      .W          (12)
   ) u_seq (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .start_i    (conv_go_ff),
      .mode8_i    (resolution_8bit_o),
      .bypass_i   (median_average_filter_bypass_o),
      .tick_i     (tick_w),
      .adc_data_i (adc_data_i),
      .busy_o     (conv_busy_o),
      .done_o     (done_w),
      .result_o   (seq_result_w)
   );

   // ==========================================================
   // Bus protocol engine
   reg  [2:0]  state_ff;
   reg  [3:0]  bit_cnt_ff;
   reg  [7:0]  shift_ff;
   reg  [7:0]  tx_ff;
   reg         rw_ff;
   reg         second_ff;
   reg  [11:0] result_ff;
   reg  [11:0] hold_ff;
   reg  [1:0]  pd_ff;
   wire [3:0]  fs_next_w = {shift_ff[2:0], sda_s_ff};

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff    <= ST_IDLE;
         bit_cnt_ff  <= 4'h0;
         shift_ff    <= 8'h00;
         tx_ff       <= 8'hFF;
         rw_ff       <= 1'b0;
         second_ff   <= 1'b0;
         result_ff   <= `TAICR_RST_RESULT;
         hold_ff     <= `TAICR_RST_RESULT;
         pd_ff       <= `TAICR_RST_PD;
         conv_go_ff  <= 1'b0;
         acq_ff      <= 1'b0;
         sda_o       <= 1'b0;
         sda_oe_o    <= 1'b0;
         function_select_o   <= 4'h0;
         mux_enable_o        <= 1'b0;
         ref_single_ended_o  <= 1'b0;
         panel_drivers_o     <= `TAICR_DRV_NONE;
         data_ready_o        <= 1'b0;
         adc_powered_o       <= 1'b0;
         pen_interrupt_en_o  <= 1'b1;
         median_average_filter_bypass_o <= `TAICR_RST_BYPASS;
         pen_pullup_sel_o    <= `TAICR_RST_PULLUP;
         resolution_8bit_o   <= 1'b0;
      end else begin
         conv_go_ff <= 1'b0;
         if (done_w) begin
            result_ff          <= seq_result_w;
            data_ready_o       <= 1'b1;
            panel_drivers_o    <= `TAICR_DRV_NONE;
            adc_powered_o      <= (pd_ff != `TAICR_PD_DOWN);
            pen_interrupt_en_o <= ~pd_ff[0];
         end
         if (start_w || stop_w) begin
            state_ff   <= start_w ? ST_ADDR : ST_IDLE;
            bit_cnt_ff <= 4'h0;
            sda_oe_o   <= 1'b0;
            if (acq_ff) begin
               acq_ff       <= 1'b0;
               mux_enable_o <= 1'b0;
               conv_go_ff   <= 1'b1;
            end
         end else begin
            case (state_ff)
               ST_ADDR: begin
                  if (scl_rise_w) begin
                     shift_ff   <= {shift_ff[6:0], sda_s_ff};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end
                  if (scl_fall_w && bit_cnt_ff == `TAICR_BYTE_BITS) begin
                     if (shift_ff[7:1] == {ADDR_BASE, pins_s_ff}) begin
                        sda_oe_o <= 1'b1;
                        rw_ff    <= shift_ff[0];
                        state_ff <= ST_ADDR_ACK;
                     end else begin
                        state_ff <= ST_IDLE;
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  if (scl_fall_w) begin
                     bit_cnt_ff <= 4'h0;
                     if (rw_ff) begin
                        // Snapshot so a finishing conversion cannot tear the read
                        hold_ff      <= result_ff;
                        tx_ff        <= result_ff[11:4];
                        sda_oe_o     <= ~result_ff[11];
                        bit_cnt_ff   <= 4'h1;
                        second_ff    <= 1'b0;
                        data_ready_o <= done_w; // Set on done wins over clear
                        state_ff     <= ST_RD;
                     end else begin
                        sda_oe_o <= 1'b0;
                        state_ff <= ST_CMD;
                     end
                  end
               end
               ST_CMD: begin
                  if (scl_rise_w) begin
                     shift_ff   <= {shift_ff[6:0], sda_s_ff};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                     if (bit_cnt_ff == `TAICR_FS_BIT_COUNT - 4'h1) begin
                        function_select_o  <= fs_next_w;
                        ref_single_ended_o <= ~fs_next_w[3];
                     end
                  end
                  if (scl_fall_w && bit_cnt_ff == `TAICR_FS_BIT_COUNT) begin
                     if (is_meas(function_select_o)) begin
                        acq_ff          <= 1'b1;
                        mux_enable_o    <= 1'b1;
                        adc_powered_o   <= 1'b1;
                        panel_drivers_o <= drv_of(function_select_o);
                     end else if (is_drv_only(function_select_o)) begin
                        panel_drivers_o <= drv_of(function_select_o);
                     end
                  end
                  if (scl_fall_w && bit_cnt_ff == `TAICR_BYTE_BITS) begin
                     if (function_select_o == `TAICR_FS_SETUP) begin
                        // Held until power-on reset only
                        median_average_filter_bypass_o <= shift_ff[`TAICR_SET_BYP_BIT];
                        pen_pullup_sel_o <= shift_ff[`TAICR_SET_PULL_BIT];
                     end else begin
                        pd_ff             <= shift_ff[`TAICR_CMD_PD_MSB:`TAICR_CMD_PD_LSB];
                        resolution_8bit_o <= shift_ff[`TAICR_CMD_MODE_BIT];
                        if (!is_meas(function_select_o)) begin
                           adc_powered_o <= (shift_ff[3:2] != `TAICR_PD_DOWN);
                           pen_interrupt_en_o <= ~shift_ff[`TAICR_CMD_PD_LSB];
                        end
                     end
                     if (is_meas(function_select_o) || is_drv_only(function_select_o)) begin
                        sda_oe_o <= 1'b1;
                        state_ff <= ST_CMD_ACK;
                     end else begin
                        state_ff <= ST_IGNORE;
                     end
                  end
               end
               ST_CMD_ACK: begin
                  if (scl_fall_w) begin
                     sda_oe_o <= 1'b0;
                     state_ff <= ST_IGNORE;
                  end
               end
               ST_IGNORE: begin
                  sda_oe_o <= 1'b0;
               end
               ST_RD: begin
                  if (scl_fall_w) begin
                     if (bit_cnt_ff == `TAICR_BYTE_BITS) begin
                        sda_oe_o <= 1'b0;
                        state_ff <= ST_RD_ACK;
                     end else begin
                        sda_oe_o   <= ~tx_ff[6];
                        tx_ff      <= {tx_ff[6:0], 1'b1};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                     end
                  end
               end
               ST_RD_ACK: begin
                  if (scl_rise_w && sda_s_ff) begin
                     state_ff <= ST_IDLE;
                  end else if (scl_fall_w) begin
                     if (!second_ff) begin
                        tx_ff    <= {hold_ff[3:0], 4'h0};
                        sda_oe_o <= ~hold_ff[3];
                     end else begin
                        tx_ff    <= 8'hFF;
                        sda_oe_o <= 1'b0;
                     end
                     second_ff  <= 1'b1;
                     bit_cnt_ff <= 4'h1;
                     state_ff   <= ST_RD;
                  end
               end
               default: begin
                  sda_oe_o <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule

/* verif/taicr_checker.sv */
`timescale 1ns/1ps
`include "taicr_defs.vh"
module taicr_checker (
   // Clock and reset
   input wire       clk_i,
   input wire       rst_i,
   // Observed ports
   input wire       scl_i,
   input wire       sda_oe_o,
   input wire [3:0] function_select_o,
   input wire       mux_enable_o,
   input wire [3:0] panel_drivers_o,
   input wire       conv_busy_o,
   input wire       data_ready_o,
   input wire       resolution_8bit_o
);
   // ==========
   // Helpers
   wire [3:0]  fs  = function_select_o;
   wire        pos = fs[3:2] == 2'h3;
   wire        drv_only = fs[3:2] == 2'h2;
   wire [3:0]  want = (fs == `TAICR_FS_X) ? `TAICR_DRV_X :
                      (fs == `TAICR_FS_Y) ? `TAICR_DRV_Y : `TAICR_DRV_XM_YP;
   reg  [11:0] len_ff;
   // Busy length, cleared when idle
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         len_ff <= 12'h000;
      else
         len_ff <= conv_busy_o ? len_ff + 12'h001 : 12'h000;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========
   // Assertions
   a_mux_busy_off: assert property (conv_busy_o |-> !mux_enable_o)
      else $error("mux connected while converting");
   a_drv_conv: assert property (conv_busy_o && pos |-> panel_drivers_o == want)
      else $error("drivers wrong while converting");
   a_drv_acq: assert property (mux_enable_o && pos |-> panel_drivers_o == want)
      else $error("drivers wrong while acquiring");
   a_acq_scl_low: assert property ($rose(mux_enable_o) |-> !scl_i)
      else $error("acquisition not on a clock fall");
   a_conv_start: assert property ($fell(mux_enable_o) && !drv_only |->
      ##[1:3] conv_busy_o)
      else $error("conversion did not follow acquisition");
   a_ready_done: assert property ($fell(conv_busy_o) |-> ##[0:2] data_ready_o)
      else $error("no result after conversion");
   a_len_8b: assert property ($fell(conv_busy_o) && resolution_8bit_o |->
      (len_ff >= 12'h037 && len_ff <= 12'h042) || (len_ff >= 12'h275 && len_ff <= 12'h281))
      else $error("eight-bit conversion length wrong");
   a_len_12b: assert property ($fell(conv_busy_o) && !resolution_8bit_o |->
      (len_ff >= 12'h090 && len_ff <= 12'h09E) || (len_ff >= 12'h5C2 && len_ff <= 12'h5D0))
      else $error("twelve-bit conversion length wrong");
   a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data changed while bus clock high");
   // Main scenarios
   c_conv_8b: cover property ($fell(conv_busy_o) && resolution_8bit_o);
   c_conv_12b: cover property ($fell(conv_busy_o) && !resolution_8bit_o);
   c_drive: cover property ($rose(sda_oe_o));
endmodule
bind taicr_i2c_touch_adc taicr_checker i_taicr_checker (
   .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
   .function_select_o(function_select_o), .mux_enable_o(mux_enable_o),
   .panel_drivers_o(panel_drivers_o), .conv_busy_o(conv_busy_o),
   .data_ready_o(data_ready_o), .resolution_8bit_o(resolution_8bit_o));

/* verif/taicr_i2c_master.sv */
`timescale 1ns/1ps
module taicr_i2c_master (
   // Clock
   input  wire clk_i,
   // Bus, data open drain
   input  wire sda_i,
   output reg  scl_o,
   output reg  sda_low_o
);
   // Bus clock idles high between frames
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // Quarter of the 400 ns bus period
   task q;
      begin
         repeat (2) @(posedge clk_i);
         #1;
      end
   endtask
   // Also a repeated start from a low clock
   task start;
      begin
         sda_low_o = 1'b0;
         q;
         scl_o = 1'b1;
         q;
         sda_low_o = 1'b1;
         q;
         scl_o = 1'b0;
         q;
      end
   endtask
   task stop;
      begin
         sda_low_o = 1'b1;
         q;
         scl_o = 1'b1;
         q;
         sda_low_o = 1'b0;
         q;
      end
   endtask
   // Data set in clock low, sampled mid high
   task xbit(input b, output s);
      begin
         sda_low_o = !b;
         q;
         scl_o = 1'b1;
         q;
         s = sda_i;
         q;
         scl_o = 1'b0;
         q;
      end
   endtask
   // Eight bits then the ninth slot; ack 0 is taken by caller
   task xbyte(input [7:0] d, input ack, output [7:0] r, output a);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1)
            xbit(d[i], r[i]);
         xbit(ack, a);
      end
   endtask
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps
`include "taicr_defs.vh"
module tb_top;
   // ==========
   // Signals
   localparam [6:0] ADDR = {5'h0A, 2'h2};
   reg         clk_i;
   reg         rst_i;
   reg  [11:0] adc;
   reg  [1:0]  pins;
   wire        scl, mlow, oe, sda, mux, busy, rdy, pwr, pen, byp, res8, sdo, refse, pup;
   wire [3:0]  fs;
   wire [3:0]  drv;
   reg  [7:0]  r;
   reg         a;
   integer     errors, comparisons, cyc;
   // Pulled up unless someone drives low
   assign sda = !(oe | mlow);
   // ==========
   // Instances
   taicr_i2c_touch_adc i_taicr_i2c_touch_adc (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl),
      .sda_i(sda), .sda_o(sdo), .sda_oe_o(oe), .addr_select_pins_i(pins), .adc_data_i(adc),
      .function_select_o(fs), .mux_enable_o(mux), .ref_single_ended_o(refse),
      .panel_drivers_o(drv), .conv_busy_o(busy), .data_ready_o(rdy), .adc_powered_o(pwr),
      .pen_interrupt_en_o(pen), .median_average_filter_bypass_o(byp),
      .pen_pullup_sel_o(pup), .resolution_8bit_o(res8));
   taicr_i2c_master i_m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(mlow));
   // ==========
   // Tasks
   task chk(input [63:0] nm, input [11:0] e, input [11:0] g);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("wrong value %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task chk1(input [63:0] nm, input e, input g);
      chk(nm, {11'h0, e}, {11'h0, g});
   endtask
   task wr(input [7:0] c, input ea);
      begin
         i_m.start;
         i_m.xbyte({ADDR, 1'b0}, 1'b1, r, a);
         chk1("wr ack", 1'b0, a);
         i_m.xbyte(c, 1'b1, r, a);
         chk1("cmd ack", ea, a);
      end
   endtask
   task rd_addr;
      begin
         repeat (200) #50;
         i_m.start;
         i_m.xbyte({ADDR, 1'b1}, 1'b1, r, a);
         chk1("rd ack", 1'b0, a);
      end
   endtask
   task conv(input integer lo, input integer hi, input [3:0] ed);
      integer n;
      begin
         for (n = 0; n < 10 && busy !== 1'b1; n = n + 1) #50;
         chk1("busy", 1'b1, busy);
         chk1("mux", 1'b0, mux);
         chk("drivers", {8'h0, ed}, {8'h0, drv});
         for (n = 0; n < 3000 && busy === 1'b1; n = n + 1) #50;
         chk1("length", 1'b1, n >= lo && n <= hi);
         repeat (4) #50;
         chk1("ready", 1'b1, rdy);
      end
   endtask
   // ==========
   // Scenarios
   task s_filt;
      begin
         wr(8'hC4, 1'b0);
         i_m.xbyte(8'h00, 1'b1, r, a);
         chk1("extra", 1'b1, a);
         chk("fsel", {8'h0, `TAICR_FS_X}, {8'h0, fs});
         chk1("acquire", 1'b1, mux);
         chk("drivers", {8'h0, `TAICR_DRV_X}, {8'h0, drv});
         i_m.stop;
         conv(1474, 1488, `TAICR_DRV_X);
         rd_addr;
         i_m.xbyte(8'hFF, 1'b0, r, a);
         chk("byte1", 12'h0A5, {4'h0, r});
         i_m.xbyte(8'hFF, 1'b0, r, a);
         chk("byte2", 12'h0C0, {4'h0, r});
         i_m.xbyte(8'hFF, 1'b1, r, a);
         chk("byte3", 12'h0FF, {4'h0, r});
         i_m.stop;
         chk1("powered", 1'b1, pwr);
         chk1("pen", 1'b0, pen);
         chk1("sda out", 1'b0, sdo);
      end
   endtask
   // Strap change makes the bench address foreign
   task s_byp8;
      begin
         pins = 2'h3;
         i_m.start;
         i_m.xbyte({ADDR, 1'b0}, 1'b1, r, a);
         chk1("foreign", 1'b1, a);
         i_m.stop;
         pins = 2'h2;
         wr(8'h10, 1'b1);
         i_m.stop;
         chk1("reserved", 1'b0, mux);
         chk1("refmode", 1'b1, refse);
         wr(8'hB3, 1'b1);
         i_m.stop;
         chk1("bypass", 1'b1, byp);
         chk1("pullup", 1'b1, pup);
         wr(8'hD2, 1'b0);
         chk("drivers", {8'h0, `TAICR_DRV_Y}, {8'h0, drv});
         i_m.stop;
         chk1("mode", 1'b1, res8);
         conv(55, 66, `TAICR_DRV_Y);
         chk1("powered", 1'b0, pwr);
         chk1("pen", 1'b1, pen);
         rd_addr;
         i_m.xbyte(8'hFF, 1'b1, r, a);
         chk("byte1", 12'h0A5, {4'h0, r});
         i_m.stop;
         chk1("ready", 1'b0, rdy);
      end
   endtask
   // Repeated start closes the acquisition here
   task s_z;
      begin
         wr(8'h80, 1'b0);
         i_m.stop;
         chk("drvonly", {8'h0, `TAICR_DRV_X}, {8'h0, drv});
         wr(8'hE0, 1'b0);
         chk("drivers", {8'h0, `TAICR_DRV_XM_YP}, {8'h0, drv});
         i_m.start;
         i_m.stop;
         conv(144, 158, `TAICR_DRV_XM_YP);
         chk1("mode", 1'b0, res8);
      end
   endtask
   task end_of_test;
      begin
         $display("errors %0d comparisons %0d", errors, comparisons);
         if (errors == 0 && comparisons > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   // ==========
   // Clock, timeout, sequence
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   initial cyc = 0;
   always @(posedge clk_i) begin
      cyc = cyc + 1;
      if (cyc == 12000) begin
         errors = errors + 1;
         end_of_test;
      end
   end
   initial begin
      errors = 0;
      comparisons = 0;
      rst_i = 1'b1;
      adc = 12'hA5C;
      pins = 2'h2;
      repeat (20) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      repeat (4) #50;
      s_filt;
      s_byp8;
      s_z;
      end_of_test;
   end
endmodule
